/* logic/acs_pkg.sv */
// constants and types for the calibration sequencer
// assumes a single 50 MHz clock domain
package acs_pkg;
    localparam int unsigned CLK_HZ          = 50_000_000;
    localparam int unsigned OSC_PER_MOD_CLK = 1;
    localparam int unsigned NOTCH_MUL       = 512;
    localparam logic [10:0] NOTCH_MIN       = 11'h00A;
    localparam logic [10:0] NOTCH_RESET     = 11'h00A;
    localparam int unsigned COEF_W          = 24;
    localparam logic [23:0] OFFSET_RESET    = 24'h000000;
    localparam logic [23:0] FULLSCALE_RESET = 24'h800000;
    localparam logic [2:0]  WAIT_SETTLE     = 3'h3;
    localparam logic [2:0]  WAIT_SYSTEM     = 3'h4;
    localparam logic [2:0]  WAIT_GAIN_LAST  = 3'h1;

    typedef enum logic [2:0] {
        ACS_MODE_CONVERT   = 3'h0,
        ACS_MODE_SELF      = 3'h1,
        ACS_MODE_SYS_OFS   = 3'h2,
        ACS_MODE_SYS_PFS   = 3'h3,
        ACS_MODE_SYS_NFS   = 3'h4,
        ACS_MODE_SYS_OFS_I = 3'h5,
        ACS_MODE_SYS_GAIN  = 3'h6,
        ACS_MODE_RESERVED  = 3'h7
    } acs_mode_e;

    // analog front-end routing
    typedef enum logic [1:0] {
        ACS_IN_EXTERNAL = 2'h0,
        ACS_IN_SHORTED  = 2'h1,
        ACS_IN_REF_POS  = 2'h2,
        ACS_IN_REF_NEG  = 2'h3
    } acs_route_e;
endpackage : acs_pkg

/* logic/acs_period_if.sv */
// carrier between the sequencer and its conversion period divider
// assumes both ends share clk
`timescale 1ns/1ps
`default_nettype none
interface acs_period_if;
    logic        restart;
    logic [10:0] notch_code;
    logic        period_tick;
    modport seq (output restart, output notch_code, input period_tick);
    modport div (input restart, input notch_code, output period_tick);
endinterface : acs_period_if
`default_nettype wire

/* logic/acs_period_div.sv */
// conversion period divider: one pulse per 512 x notch_code clocks
// assumes clk is the master oscillator
`timescale 1ns/1ps
`default_nettype none
module acs_period_div (
    input  wire logic   clk,
    input  wire logic   rst,
    acs_period_if.div   pif
);
    import acs_pkg::*;

    logic [19:0] cnt_q;
    logic [19:0] limit;
    logic [10:0] code_eff;

    // codes below the usable floor are clamped, keeps the period sane
    assign code_eff = (pif.notch_code < NOTCH_MIN) ? NOTCH_MIN : pif.notch_code;
    assign limit    = 20'(code_eff) * 20'(NOTCH_MUL) - 20'h00001;

    always_ff @(posedge clk) begin
        if (rst || pif.restart) begin
            cnt_q           <= 20'h00000;
            pif.period_tick <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q           <= 20'h00000;
            pif.period_tick <= 1'b1;
        end else begin
            cnt_q           <= cnt_q + 20'h00001;
            pif.period_tick <= 1'b0;
        end
    end
endmodule : acs_period_div
`default_nettype wire

/* logic/acs_sequencer.sv */
// operating mode and calibration sequencer of a sigma-delta converter
// assumes mode and notch code come from a register port on clk;
// filter result arrives as a same-clock word
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire acs_pkg::acs_mode_e   op_mode_select,
    input  wire logic [10:0]          notch_code,
    input  wire logic [23:0]          filter_result,
    input  wire logic                 ofs_wr,
    input  wire logic                 pfs_wr,
    input  wire logic                 nfs_wr,
    input  wire logic [23:0]          coef_wdata,
    output logic [23:0]               offset_coef,
    output logic [23:0]               pos_fs_coef,
    output logic [23:0]               neg_fs_coef,
    output logic [23:0]               data_out,
    output acs_pkg::acs_route_e       input_route,
    output logic                      input_invert,
    output logic                      result_valid_n
);
    import acs_pkg::*;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'b000001,
        ST_OFS   = 6'b000010,
        ST_PFS   = 6'b000100,
        ST_NFS   = 6'b001000,
        ST_FINAL = 6'b010000,
        ST_DONE  = 6'b100000
    } acs_state_e;

    acs_period_if pif ();

    acs_period_div u_div (
        .clk (clk),
        .rst (rst),
        .pif (pif)
    );

    acs_mode_e   mode_q;
    acs_state_e  state_q;
    logic [2:0]  per_q;
    logic        mode_chg;
    logic        phase_end;
    logic [2:0]  wait_len;

    // length of the phase that is running, counted in periods
    function automatic logic [2:0] acs_phase_len(input acs_mode_e m, input acs_state_e s);
        logic [2:0] len;
        len = WAIT_SETTLE;
        case (m)
            ACS_MODE_SYS_OFS, ACS_MODE_SYS_PFS, ACS_MODE_SYS_NFS: begin
                len = WAIT_SYSTEM;
            end
            ACS_MODE_SYS_OFS_I: begin
                len = (s == ST_OFS) ? WAIT_SYSTEM : WAIT_SETTLE;
            end
            ACS_MODE_SYS_GAIN: begin
                len = (s == ST_FINAL) ? WAIT_GAIN_LAST : WAIT_SETTLE;
            end
            default: begin
                len = WAIT_SETTLE;
            end
        endcase
        return len;
    endfunction : acs_phase_len

    // first phase entered for each mode
    function automatic acs_state_e acs_first(input acs_mode_e m);
        acs_state_e s;
        s = ST_FINAL;
        case (m)
            ACS_MODE_CONVERT:   s = ST_FINAL;
            ACS_MODE_SELF:      s = ST_OFS;
            ACS_MODE_SYS_OFS:   s = ST_OFS;
            ACS_MODE_SYS_PFS:   s = ST_PFS;
            ACS_MODE_SYS_NFS:   s = ST_NFS;
            ACS_MODE_SYS_OFS_I: s = ST_OFS;
            ACS_MODE_SYS_GAIN:  s = ST_NFS;
            // reserved code is not trapped; it behaves as conversion
            default:            s = ST_FINAL;
        endcase
        return s;
    endfunction : acs_first

    assign mode_chg       = (op_mode_select != mode_q);
    assign wait_len       = acs_phase_len(mode_q, state_q);
    assign phase_end      = pif.period_tick && (per_q + 3'h1 == wait_len);
    assign pif.restart    = mode_chg;
    assign pif.notch_code = notch_code;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_q <= ACS_MODE_CONVERT;
        end else begin
            mode_q <= op_mode_select;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= ST_FINAL;
            per_q   <= 3'h0;
        end else if (mode_chg) begin
            state_q <= acs_first(op_mode_select);
            per_q   <= 3'h0;
        end else if (state_q != ST_DONE && pif.period_tick) begin
            per_q <= phase_end ? 3'h0 : per_q + 3'h1;
            if (phase_end) begin
                case (state_q)
                    ST_OFS: begin
                        state_q <= (mode_q == ACS_MODE_SYS_OFS) ? ST_DONE : ST_PFS;
                    end
                    ST_PFS: begin
                        if (mode_q == ACS_MODE_SYS_PFS) begin
                            state_q <= ST_DONE;
                        end else if (mode_q == ACS_MODE_SYS_GAIN) begin
                            state_q <= ST_FINAL;
                        end else begin
                            state_q <= ST_NFS;
                        end
                    end
                    ST_NFS: begin
                        if (mode_q == ACS_MODE_SYS_NFS) begin
                            state_q <= ST_DONE;
                        end else if (mode_q == ACS_MODE_SYS_GAIN) begin
                            state_q <= ST_PFS;
                        end else begin
                            state_q <= ST_FINAL;
                        end
                    end
                    ST_FINAL: state_q <= ST_DONE;
                    default:  state_q <= state_q;
                endcase
            end
        end
    end

    // analog routing per phase; system modes keep the external input, except ACS_MODE_SYS_OFS_I in its pos and neg reference phases
    always_ff @(posedge clk) begin
        if (rst) begin
            input_route  <= ACS_IN_EXTERNAL;
            input_invert <= 1'b0;
        end else begin
            input_route  <= ACS_IN_EXTERNAL;
            input_invert <= 1'b0;
            if (mode_q == ACS_MODE_SELF && state_q == ST_OFS) begin
                input_route <= ACS_IN_SHORTED;
            end else if ((mode_q == ACS_MODE_SELF || mode_q == ACS_MODE_SYS_OFS_I)
                         && state_q == ST_PFS) begin
                input_route <= ACS_IN_REF_POS;
            end else if ((mode_q == ACS_MODE_SELF || mode_q == ACS_MODE_SYS_OFS_I)
                         && state_q == ST_NFS) begin
                input_route <= ACS_IN_REF_NEG;
            end else if (mode_q == ACS_MODE_SYS_GAIN && state_q == ST_PFS) begin
                input_invert <= 1'b1;
            end
        end
    end

    // coefficient store; phase end wins over a host write the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            offset_coef <= OFFSET_RESET;
            pos_fs_coef <= FULLSCALE_RESET;
            neg_fs_coef <= FULLSCALE_RESET;
        end else begin
            if (phase_end && !mode_chg && state_q == ST_OFS) begin
                offset_coef <= filter_result;
            end else if (ofs_wr) begin
                offset_coef <= coef_wdata;
            end
            if (phase_end && !mode_chg && state_q == ST_PFS) begin
                pos_fs_coef <= filter_result;
            end else if (pfs_wr) begin
                pos_fs_coef <= coef_wdata;
            end
            if (phase_end && !mode_chg && state_q == ST_NFS) begin
                neg_fs_coef <= filter_result;
            end else if (nfs_wr) begin
                neg_fs_coef <= coef_wdata;
            end
        end
    end

    // result is captured each period once the mode has settled; in
    // conversion no coefficient is touched, correction happens downstream
    always_ff @(posedge clk) begin
        if (rst) begin
            data_out <= 24'h000000;
        end else if (pif.period_tick && !mode_chg
                     && (state_q == ST_DONE || phase_end)) begin
            data_out <= filter_result;
        end
    end

    // ready goes low for one period tick cycle per new result
    always_ff @(posedge clk) begin
        if (rst || mode_chg) begin
            result_valid_n <= 1'b1;
        end else if (pif.period_tick && (state_q == ST_DONE
                     || (phase_end && (state_q == ST_FINAL
                     || mode_q == ACS_MODE_SYS_OFS || mode_q == ACS_MODE_SYS_PFS
                     || mode_q == ACS_MODE_SYS_NFS)))) begin
            result_valid_n <= 1'b0;
        end else begin
            result_valid_n <= 1'b1;
        end
    end
endmodule : acs_sequencer
`default_nettype wire

/* testbench/acs_sequencer_chk.sv */
// port checker for the calibration sequencer
// assumes binding into acs_sequencer, single clock domain
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_chk (
    input wire logic               clk,
    input wire logic               rst,
    input wire acs_pkg::acs_mode_e op_mode_select,
    input wire logic [10:0]        notch_code,
    input wire logic               ofs_wr,
    input wire logic               pfs_wr,
    input wire logic               nfs_wr,
    input wire logic [23:0]        offset_coef,
    input wire logic [23:0]        pos_fs_coef,
    input wire logic [23:0]        neg_fs_coef,
    input wire acs_pkg::acs_route_e input_route,
    input wire logic               input_invert,
    input wire logic               result_valid_n
);
    import acs_pkg::*;
    // periods to offset, pos, neg write and to ready; 0 means never
    localparam int KTAB[8][4] = '{'{0,0,0,3}, '{3,6,9,12}, '{4,0,0,4}, '{0,4,0,4},
                                  '{0,0,4,4}, '{4,7,10,13}, '{0,6,3,7}, '{0,0,0,3}};
    acs_mode_e mode_q;
    int        cyc_q;
    int        p;
    logic      first_q;
    logic      chg;
    assign chg = rst || (op_mode_select != mode_q);
    assign p   = 512 * ((notch_code < NOTCH_MIN) ? 10 : int'(notch_code));
    // slack of a few clocks: only the period figure is pinned down
    function automatic bit near(int c, int k);
        return k > 0 && c >= k * p - 2 && c <= k * p + 3;
    endfunction : near
    always_ff @(posedge clk) mode_q <= rst ? ACS_MODE_CONVERT : op_mode_select;
    always_ff @(posedge clk) cyc_q <= chg ? 0 : cyc_q + 1;
    always_ff @(posedge clk) first_q <= chg | (first_q & result_valid_n);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_ready_time: assert property (
        !result_valid_n && first_q |-> near(cyc_q, KTAB[mode_q][3])) else $error("ready timing");
    a_ready_pulse: assert property (
        !result_valid_n |=> result_valid_n) else $error("ready too long");
    a_restart_quiet: assert property (
        chg |-> ##2 result_valid_n [*8]) else $error("ready after mode change");
    a_ofs_write: assert property (
        $changed(offset_coef) && !$past(ofs_wr) && cyc_q > 4 |-> near(cyc_q, KTAB[mode_q][0]))
        else $error("offset write timing");
    a_pfs_write: assert property (
        $changed(pos_fs_coef) && !$past(pfs_wr) && cyc_q > 4 |-> near(cyc_q, KTAB[mode_q][1]))
        else $error("pos write timing");
    a_nfs_write: assert property (
        $changed(neg_fs_coef) && !$past(nfs_wr) && cyc_q > 4 |-> near(cyc_q, KTAB[mode_q][2]))
        else $error("neg write timing");
    a_conv_keeps: assert property (
        mode_q == ACS_MODE_CONVERT && !(ofs_wr || pfs_wr || nfs_wr)
        |=> $stable({offset_coef, pos_fs_coef, neg_fs_coef})) else $error("coef moved");
    a_self_short: assert property (
        mode_q == ACS_MODE_SELF && cyc_q inside {[3:100]} |-> input_route == ACS_IN_SHORTED)
        else $error("self route");
    a_sys_external: assert property (
        mode_q inside {[ACS_MODE_SYS_OFS:ACS_MODE_SYS_NFS], ACS_MODE_SYS_GAIN} && cyc_q inside
        {[3:100]} |-> input_route == ACS_IN_EXTERNAL
        && (mode_q == ACS_MODE_SYS_GAIN || !input_invert)) else $error("sys route");
endmodule : acs_sequencer_chk
bind acs_sequencer acs_sequencer_chk i_chk (.clk, .rst, .op_mode_select, .notch_code, .ofs_wr,
    .pfs_wr, .nfs_wr, .offset_coef, .pos_fs_coef, .neg_fs_coef, .input_route, .input_invert,
    .result_valid_n);
`default_nettype wire

/* testbench/acs_host_model.sv */
// host side source of the settled calibration input level
// assumes the bench sets the level before selecting a mode
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
    input  wire logic        clk,
    input  wire logic [23:0] level,
    output logic      [23:0] filter_result
);
    always_ff @(posedge clk) begin
        filter_result <= level;
    end
endmodule : acs_host_model
`default_nettype wire

/* testbench/acs_sequencer_tb.sv */
// self-checking bench for the calibration sequencer
// assumes notch code 10, so one conversion period is 5120 clocks
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_tb;
    import acs_pkg::*;
    localparam int P = 512 * 10;
    localparam int KRDY[8] = '{3, 12, 4, 4, 4, 13, 7, 3};
    logic        clk, rst, ofs_wr, pfs_wr, nfs_wr, input_invert, result_valid_n;
    logic [10:0] notch_code;
    logic [23:0] level, filter_result, coef_wdata, offset_coef, pos_fs_coef, neg_fs_coef;
    logic [23:0] data_out;
    logic [71:0] coefs;
    acs_mode_e   op_mode_select;
    acs_route_e  input_route;
    int          n_mismatch = 0;
    int          n_compared = 0;
    assign coefs = {offset_coef, pos_fs_coef, neg_fs_coef};
    acs_sequencer i_dut (.clk, .rst, .op_mode_select, .notch_code, .filter_result, .ofs_wr,
        .pfs_wr, .nfs_wr, .coef_wdata, .offset_coef, .pos_fs_coef, .neg_fs_coef,
        .data_out, .input_route, .input_invert, .result_valid_n);
    acs_host_model i_host (.clk, .level, .filter_result);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %0h, seen %0h", what, exp, seen);
        end
    endtask : chk
    task automatic end_sim;
        $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim
    task automatic set_mode(input acs_mode_e m);
        @(posedge clk);
        op_mode_select <= m;
    endtask : set_mode
    task automatic host_wr(input int w, input logic [23:0] v);
        @(posedge clk);
        coef_wdata <= v;
        {ofs_wr, pfs_wr, nfs_wr} <= {w == 0, w == 1, w == 2};
        @(posedge clk);
        {ofs_wr, pfs_wr, nfs_wr} <= 3'h0;
    endtask : host_wr
    // bounded wait: a missing ready shows as a late count, not a hang
    task automatic wait_ready(input acs_mode_e m);
        int   n;
        logic ok;
        set_mode(m);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (result_valid_n !== 1'b0 && n < 14 * P);
        ok = n inside {[KRDY[m] * P - 1 : KRDY[m] * P + 3]};
        chk("ready delay", {71'h0, ok}, 72'h1);
    endtask : wait_ready
    task automatic t_decode;
        // reserved code is never selected by the host
        for (int m = 0; m < 7; m++) begin
            set_mode(acs_mode_e'(m));
            repeat (6) @(posedge clk);
            #1;
            chk("route", {70'h0, input_route}, (m == 1) ? 72'h1 : 72'h0);
            chk("quiet", {70'h0, input_invert, result_valid_n}, 72'h1);
        end
    endtask : t_decode
    task automatic t_convert;
        host_wr(0, 24'h123456);
        host_wr(1, 24'h9ABCDE);
        host_wr(2, 24'h654321);
        wait_ready(ACS_MODE_CONVERT);
        chk("kept coefs", coefs, 72'h1234569ABCDE654321);
        chk("conv data", {48'h0, data_out}, 72'h0);
        host_wr(0, 24'h000000);
        host_wr(1, 24'h800000);
        host_wr(2, 24'h800000);
        @(posedge clk);
        #1;
        chk("raw coefs", coefs, 72'h000000800000800000);
    endtask : t_convert
    task automatic t_cal;
        level <= 24'hABCDE1;
        wait_ready(ACS_MODE_SYS_OFS);
        chk("sys offset", coefs, 72'hABCDE1800000800000);
        chk("sys data", {48'h0, data_out}, 72'hABCDE1);
        level <= 24'h5A5A5A;
        set_mode(ACS_MODE_SYS_NFS);
        repeat (40) @(posedge clk);
        wait_ready(ACS_MODE_SELF);
        chk("self coefs", coefs, 72'h5A5A5A5A5A5A5A5A5A);
        chk("self data", {48'h0, data_out}, 72'h5A5A5A);
    endtask : t_cal
    initial begin
        rst            = 1'b1;
        op_mode_select = ACS_MODE_CONVERT;
        // notch, gain and range never change here, so no recalibration is owed
        notch_code     = 11'h00A;
        level          = 24'h000000;
        coef_wdata     = 24'h000000;
        {ofs_wr, pfs_wr, nfs_wr} = 3'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk("reset coefs", coefs, 72'h000000800000800000);
        t_decode();
        t_convert();
        t_cal();
        end_sim();
    end
    initial begin
        // tests need about 19 periods; half a period of margin keeps under 100k clocks
        #(39 * P * 10);
        n_mismatch++;
        end_sim();
    end
endmodule : acs_sequencer_tb
`default_nettype wire
